// [rtl/mmv_memmap_decode.sv]
// memory map decode: on-chip ram, vector table, watchdog clear and stack engine
`timescale 1ns/1ps
`default_nettype none
module mmv_memmap_decode #(
    parameter logic [15:0] VEC_DEFAULT = mmv_pkg::VEC_RESET_VAL,
    parameter logic [15:0] WDOG_LIMIT_DEF = mmv_pkg::WDOG_LIMIT_RST
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core memory access
    input wire mmv_pkg::mmv_core_req_t core_req,
    output logic core_ready,
    output var mmv_pkg::mmv_core_rsp_t core_rsp,
    // core stack operations and pending interrupt sources
    input wire mmv_pkg::mmv_stk_req_t stk_req,
    input wire logic [mmv_pkg::NUM_SRC-1:0] int_pend,
    output logic stk_ready,
    output var mmv_pkg::mmv_stk_rsp_t stk_rsp,
    output logic [15:0] stack_ptr,
    // watchdog
    output logic wdog_timeout
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic is_ram(input logic [15:0] a);
        return (a >= mmv_pkg::RAM_A_LO && a <= mmv_pkg::RAM_A_HI) ||
               (a >= mmv_pkg::RAM_B_LO && a <= mmv_pkg::RAM_B_HI);
    endfunction

    // the two windows are packed back to back into one 2048-byte array
    function automatic logic [10:0] ram_idx(input logic [15:0] a);
        logic [15:0] d;
        d = (a <= mmv_pkg::RAM_A_HI) ? a - mmv_pkg::RAM_A_LO
                                      : a - mmv_pkg::RAM_B_LO + mmv_pkg::RAM_B_IDX;
        return d[10:0];
    endfunction

    function automatic logic is_vec(input logic [15:0] a);
        return a >= mmv_pkg::VEC_BASE;
    endfunction

    function automatic logic [4:0] vec_idx(input logic [15:0] a);
        logic [15:0] d;
        d = a - mmv_pkg::VEC_BASE;
        return d[5:1];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PUSH,
        ST_PULL,
        ST_DONE
    } mmv_stk_state_t;

    mmv_stk_state_t state_reg;
    logic [7:0] ram_mem [mmv_pkg::RAM_BYTES];
    logic [15:0] vec_tab_reg [mmv_pkg::NUM_VEC];
    logic [15:0] sp_reg;
    logic [39:0] push_buf_reg;
    logic [2:0] push_cnt_reg;
    logic [7:0] stk_rdata_reg;
    logic [15:0] stk_vec_reg;
    logic stk_fault_reg;
    logic [15:0] wdog_cnt_reg;
    logic [15:0] wdog_limit_reg;
    logic wdog_timeout_reg;
    logic [1:0] status_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    mmv_pkg::mmv_core_rsp_t core_rsp_reg;

    logic core_acc;
    logic core_is_ram;
    logic core_is_vec;
    logic [15:0] vec_rd_word;
    logic [7:0] reset_lo;
    logic stk_acc;
    logic int_acc;
    logic call_acc;
    logic pull_acc;
    logic reload_acc;
    logic sp_in_ram;
    logic prio_any;
    logic [4:0] win_idx;
    logic ram_we;
    logic [10:0] ram_widx;
    logic [7:0] ram_wdata;
    logic wdog_clr;
    logic wdog_hit;
    logic apb_wr;
    logic apb_vec;
    logic [11:0] apb_voff;
    logic [4:0] apb_vidx;

    ////////////////////////////////////////////////////////////////////////////
    // handshakes and decode

    // a stack operation owns the ram port, so core accesses wait for it
    assign stk_ready = (state_reg == ST_IDLE);
    assign stk_acc = stk_ready && (stk_req.op != mmv_pkg::STK_NONE);
    assign core_ready = stk_ready && (stk_req.op == mmv_pkg::STK_NONE);
    assign core_acc = core_req.valid && core_ready;
    assign int_acc = stk_acc && (stk_req.op == mmv_pkg::STK_INT);
    assign call_acc = stk_acc && (stk_req.op == mmv_pkg::STK_CALL);
    assign pull_acc = stk_acc && (stk_req.op == mmv_pkg::STK_PULL);
    assign reload_acc = stk_acc && (stk_req.op == mmv_pkg::STK_SP_RELOAD);

    assign core_is_ram = is_ram(core_req.addr);
    assign core_is_vec = is_vec(core_req.addr);
    assign vec_rd_word = vec_tab_reg[vec_idx(core_req.addr)];
    assign reset_lo = vec_tab_reg[mmv_pkg::VEC_RESET_IDX][7:0];
    assign sp_in_ram = is_ram(sp_reg);

    mmv_vec_prio #(
        .N(mmv_pkg::NUM_SRC)
    ) u_prio (
        .pend(int_pend),
        .any(prio_any),
        .idx(win_idx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // ram

    always_comb begin
        ram_we = 1'b0;
        ram_widx = ram_idx(core_req.addr);
        ram_wdata = core_req.wdata;
        if (state_reg == ST_PUSH) begin
            // a push outside ram is dropped and flagged, never aliased
            ram_we = sp_in_ram;
            ram_widx = ram_idx(sp_reg);
            ram_wdata = push_buf_reg[39:32];
        end else if (core_acc && core_req.write) begin
            ram_we = core_is_ram;
        end
    end

    always_ff @(posedge pclk) begin
        if (ram_we) begin
            ram_mem[ram_widx] <= ram_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core access answer

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_rsp_reg <= '0;
        end else begin
            core_rsp_reg.ack <= core_acc;
            if (core_acc) begin
                core_rsp_reg.ram_hit <= core_is_ram;
                core_rsp_reg.vec_hit <= core_is_vec;
                if (core_req.write) begin
                    core_rsp_reg.rdata <= 8'h00;
                end else if (core_is_ram) begin
                    core_rsp_reg.rdata <= ram_mem[ram_idx(core_req.addr)];
                end else if (core_is_vec) begin
                    // ffff lands on the odd byte of the reset pair, never watchdog state
                    core_rsp_reg.rdata <= core_req.addr[0] ? vec_rd_word[7:0]
                                                           : vec_rd_word[15:8];
                end else begin
                    core_rsp_reg.rdata <= 8'h00;
                end
            end
        end
    end

    assign core_rsp = core_rsp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // stack engine

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            push_buf_reg <= 40'h0000000000;
            push_cnt_reg <= 3'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (stk_acc) begin
                        case (stk_req.op)
                            mmv_pkg::STK_INT: begin
                                // pc low goes first so ccr ends on top; h stays in the core
                                push_buf_reg <= {stk_req.pc[7:0], stk_req.pc[15:8],
                                                 stk_req.xr, stk_req.acc,
                                                 stk_req.ccr};
                                push_cnt_reg <= mmv_pkg::INT_PUSH_BYTES;
                                state_reg <= ST_PUSH;
                            end
                            mmv_pkg::STK_CALL: begin
                                push_buf_reg <= {stk_req.pc[7:0], stk_req.pc[15:8],
                                                 24'h000000};
                                push_cnt_reg <= mmv_pkg::CALL_PUSH_BYTES;
                                state_reg <= ST_PUSH;
                            end
                            mmv_pkg::STK_PULL: begin
                                state_reg <= ST_PULL;
                            end
                            default: begin
                                state_reg <= ST_DONE;
                            end
                        endcase
                    end
                end
                ST_PUSH: begin
                    push_buf_reg <= {push_buf_reg[31:0], 8'h00};
                    push_cnt_reg <= push_cnt_reg - 3'h1;
                    if (push_cnt_reg == 3'h1) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_PULL: begin
                    state_reg <= ST_DONE;
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // software may move the pointer only while the engine is quiet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_reg <= mmv_pkg::SP_RESET;
        end else if (state_reg == ST_PUSH) begin
            sp_reg <= sp_reg - 16'h0001;
        end else if (pull_acc) begin
            sp_reg <= sp_reg + 16'h0001;
        end else if (reload_acc) begin
            sp_reg <= {sp_reg[15:8], mmv_pkg::SP_RESET[7:0]};
        end else if (apb_wr && paddr == mmv_pkg::OFF_SP && stk_ready && !stk_acc) begin
            sp_reg <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stk_rdata_reg <= 8'h00;
            stk_vec_reg <= 16'h0000;
            stk_fault_reg <= 1'b0;
        end else begin
            if (stk_acc) begin
                stk_fault_reg <= 1'b0;
            end
            if (int_acc) begin
                // no pending line means a software interrupt
                stk_vec_reg <= prio_any ? vec_tab_reg[win_idx]
                                        : vec_tab_reg[mmv_pkg::VEC_SOFT_IDX];
            end
            if (state_reg == ST_PUSH && !sp_in_ram) begin
                stk_fault_reg <= 1'b1;
            end
            if (state_reg == ST_PULL) begin
                stk_rdata_reg <= sp_in_ram ? ram_mem[ram_idx(sp_reg)] : 8'h00;
                if (!sp_in_ram) begin
                    stk_fault_reg <= 1'b1;
                end
            end
        end
    end

    assign stk_rsp = {(state_reg == ST_DONE),
                      stk_fault_reg,
                      stk_rdata_reg,
                      stk_vec_reg};
    assign stack_ptr = sp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // watchdog

    assign wdog_clr = core_acc && core_req.write && core_req.addr == mmv_pkg::WDOG_CLR_ADDR;
    assign wdog_hit = (wdog_cnt_reg == wdog_limit_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_cnt_reg <= 16'h0000;
            wdog_timeout_reg <= 1'b0;
        end else begin
            wdog_timeout_reg <= wdog_hit && !wdog_clr;
            // the written value is ignored on purpose
            if (wdog_clr || wdog_hit) begin
                wdog_cnt_reg <= 16'h0000;
            end else begin
                wdog_cnt_reg <= wdog_cnt_reg + 16'h0001;
            end
        end
    end

    assign wdog_timeout = wdog_timeout_reg;

    ////////////////////////////////////////////////////////////////////////////
    // apb registers

    assign apb_wr = psel && penable && pwrite;
    assign apb_voff = paddr - mmv_pkg::OFF_VEC_BASE;
    assign apb_vidx = apb_voff[6:2];
    assign apb_vec = (paddr >= mmv_pkg::OFF_VEC_BASE) && (paddr[1:0] == 2'h0) &&
                     (int'(apb_voff[11:2]) < mmv_pkg::NUM_VEC);
    assign pready = psel && penable;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < mmv_pkg::NUM_VEC; i++) begin
                vec_tab_reg[i] <= VEC_DEFAULT;
            end
        end else if (apb_wr && apb_vec) begin
            vec_tab_reg[apb_vidx] <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_limit_reg <= WDOG_LIMIT_DEF;
        end else if (apb_wr && paddr == mmv_pkg::OFF_WDOG_LIMIT) begin
            wdog_limit_reg <= pwdata[15:0];
        end
    end

    // write-one-to-clear; a set in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 2'h0;
        end else begin
            if (apb_wr && paddr == mmv_pkg::OFF_STATUS) begin
                status_reg <= status_reg & ~pwdata[1:0];
            end
            if (wdog_hit && !wdog_clr) begin
                status_reg[mmv_pkg::ST_WDOG_BIT] <= 1'b1;
            end
            if (!sp_in_ram && (state_reg == ST_PUSH || state_reg == ST_PULL)) begin
                status_reg[mmv_pkg::ST_STK_BIT] <= 1'b1;
            end
        end
    end

    // read data is caught in the setup cycle so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            if (apb_vec) begin
                prdata_reg <= {16'h0000, vec_tab_reg[apb_vidx]};
            end else begin
                case (paddr)
                    mmv_pkg::OFF_SP: prdata_reg <= {16'h0000, sp_reg};
                    mmv_pkg::OFF_WDOG_CNT: prdata_reg <= {16'h0000, wdog_cnt_reg};
                    mmv_pkg::OFF_WDOG_LIMIT: prdata_reg <= {16'h0000, wdog_limit_reg};
                    mmv_pkg::OFF_STATUS: prdata_reg <= {30'h00000000, status_reg};
                    default: pslverr_reg <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_push5;
        (state_reg == ST_PUSH) [*5] ##1 (state_reg == ST_DONE);
    endsequence

    sequence s_push2;
        (state_reg == ST_PUSH) [*2] ##1 (state_reg == ST_DONE);
    endsequence

    a_vec_hi_byte: assert property (
        (core_acc && !core_req.write && core_is_vec && !core_req.addr[0]) |=>
            ({core_rsp.rdata, 8'h00} == ($past(vec_rd_word) & 16'hff00)))
        else $error("vector high byte not at even address");

    a_prio_top: assert property (
        prio_any |-> int_pend[win_idx] && (((int_pend >> win_idx) >> 1) == '0))
        else $error("interrupt winner is not the highest pending source");

    a_vec_decode: assert property (
        (core_acc && core_is_vec) |=> core_rsp.ack && core_rsp.vec_hit && !core_rsp.ram_hit)
        else $error("vector area access not decoded as vector");

    a_reset_low: assert property (
        (core_acc && !core_req.write && core_req.addr == mmv_pkg::WDOG_CLR_ADDR) |=>
            (core_rsp.rdata == $past(reset_lo)))
        else $error("ffff read did not return reset vector low byte");

    a_wdog_clear: assert property (
        wdog_clr |=> (wdog_cnt_reg == 16'h0000) && !wdog_timeout)
        else $error("write to ffff did not clear watchdog");

    a_ram_decode: assert property (
        core_acc |=> core_rsp.ack && (core_rsp.ram_hit == $past(core_is_ram)))
        else $error("ram hit flag disagrees with address");

    a_page0_ram: assert property (
        (core_acc && core_req.addr >= mmv_pkg::RAM_A_LO &&
         core_req.addr <= mmv_pkg::PAGE0_END) |=> core_rsp.ram_hit)
        else $error("page zero ram location not decoded");

    a_sp_reload: assert property (
        reload_acc |=> (sp_reg == (($past(sp_reg) & 16'hff00) | 16'h00ff)))
        else $error("stack pointer reload wrong");

    a_int_push: assert property (
        int_acc |=> s_push5 ##0 (sp_reg == $past(sp_reg, 6) - 16'h0005))
        else $error("interrupt entry did not push five bytes");

    a_call_push: assert property (
        call_acc |=> s_push2 ##0 (sp_reg == $past(sp_reg, 3) - 16'h0002))
        else $error("call did not push two bytes");

    a_pull_inc: assert property (
        pull_acc |=> (sp_reg == $past(sp_reg) + 16'h0001) ##1 stk_rsp.done)
        else $error("pull did not increment stack pointer");

endmodule // mmv_memmap_decode
`default_nettype wire

// [rtl/mmv_pkg.sv]
// package: memory map, vector table, stack and register constants
package mmv_pkg;
    // on-chip ram windows
    localparam int RAM_BYTES = 2048;
    localparam logic [15:0] RAM_A_LO = 16'h0050;
    localparam logic [15:0] RAM_A_HI = 16'h044f;
    localparam logic [15:0] RAM_B_LO = 16'h0a00;
    localparam logic [15:0] RAM_B_HI = 16'h0dff;
    localparam logic [15:0] RAM_B_IDX = 16'h0400;
    localparam logic [15:0] PAGE0_END = 16'h00ff;
    localparam int PAGE0_RAM_BYTES = 176;

    // vector table: pair i sits at VEC_BASE + 2*i, high byte first
    localparam logic [15:0] VEC_BASE = 16'hffcc;
    localparam int NUM_VEC = 26;
    localparam int NUM_SRC = 25;
    localparam logic [4:0] VEC_SOFT_IDX = 5'h18;
    localparam logic [4:0] VEC_RESET_IDX = 5'h19;
    localparam logic [15:0] WDOG_CLR_ADDR = 16'hffff;

    // stack
    localparam logic [15:0] SP_RESET = 16'h00ff;
    localparam logic [2:0] INT_PUSH_BYTES = 3'h5;
    localparam logic [2:0] CALL_PUSH_BYTES = 3'h2;

    // reset values
    localparam logic [15:0] VEC_RESET_VAL = 16'h0000;
    localparam logic [15:0] WDOG_LIMIT_RST = 16'hffff;

    // apb byte offsets
    localparam logic [11:0] OFF_SP = 12'h000;
    localparam logic [11:0] OFF_WDOG_CNT = 12'h004;
    localparam logic [11:0] OFF_WDOG_LIMIT = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [11:0] OFF_VEC_BASE = 12'h100;

    // status bit positions
    localparam int ST_WDOG_BIT = 0;
    localparam int ST_STK_BIT = 1;

    typedef enum logic [2:0] {
        STK_NONE,
        STK_INT,
        STK_CALL,
        STK_PULL,
        STK_SP_RELOAD
    } mmv_stk_op_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mmv_core_req_t;

    typedef struct packed {
        logic ack;
        logic ram_hit;
        logic vec_hit;
        logic [7:0] rdata;
    } mmv_core_rsp_t;

    typedef struct packed {
        mmv_stk_op_t op;
        logic [15:0] pc;
        logic [7:0] xr;
        logic [7:0] acc;
        logic [7:0] ccr;
    } mmv_stk_req_t;

    typedef struct packed {
        logic done;
        logic fault;
        logic [7:0] rdata;
        logic [15:0] vec_addr;
    } mmv_stk_rsp_t;
endpackage

// [rtl/mmv_vec_prio.sv]
// fixed priority picker: the pending source at the highest vector address wins
`timescale 1ns/1ps
`default_nettype none
module mmv_vec_prio #(
    parameter int N = 25
) (
    // pending sources, index 0 at the lowest vector address
    input wire logic [N-1:0] pend,
    // winner
    output logic any,
    output logic [4:0] idx
);
    always_comb begin
        any = 1'b0;
        idx = 5'h00;
        // later iterations overwrite, so the highest index wins
        for (int i = 0; i < N; i++) begin
            if (pend[i]) begin
                any = 1'b1;
                idx = 5'(i);
            end
        end
    end
endmodule // mmv_vec_prio
`default_nettype wire

// [testbench/mmv_core_model.sv]
// processor core model: byte accesses and stack operations
`timescale 1ns/1ps
`default_nettype none
module mmv_core_model (
    // clock
    input wire logic pclk,
    // requests
    output var mmv_pkg::mmv_core_req_t core_req,
    output var mmv_pkg::mmv_stk_req_t stk_req,
    output logic [mmv_pkg::NUM_SRC-1:0] int_pend,
    // answers
    input wire logic core_ready,
    input wire mmv_pkg::mmv_core_rsp_t core_rsp,
    input wire logic stk_ready,
    input wire mmv_pkg::mmv_stk_rsp_t stk_rsp
);
    initial begin
        core_req = '0;
        stk_req = '0;
        int_pend = '0;
    end
    // released fields show inverted values so stale data cannot pass
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
                          output logic [7:0] r, output logic hit);
        core_req <= {1'b1, w, a, d};
        do @(posedge pclk); while (core_ready !== 1'b1);
        core_req <= {1'b0, w, ~a, ~d};
        @(posedge pclk);
        #1;
        r = core_rsp.rdata;
        hit = core_rsp.ram_hit;
    endtask
    task automatic stack(input mmv_pkg::mmv_stk_op_t op, input logic [15:0] pc,
                         input logic [23:0] xac, input logic [24:0] pend, output int lat);
        stk_req <= {op, pc, xac};
        int_pend <= pend;
        do @(posedge pclk); while (stk_ready !== 1'b1);
        stk_req <= {mmv_pkg::STK_NONE, ~pc, ~xac};
        lat = 0;
        do begin
            @(posedge pclk);
            lat++;
        end while (stk_rsp.done !== 1'b1 && lat < 20);
    endtask
endmodule // mmv_core_model
`default_nettype wire

// [testbench/test_memory_map_vector_decode.sv]
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module test_memory_map_vector_decode;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, core_ready, stk_ready, hit, err, wdog_timeout;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, x, pend, seed = 32'h8;
    logic [15:0] stack_ptr, sp;
    logic [7:0] b;
    logic [7:0] e[5];
    logic [15:0] vec[26];
    logic [15:0] ad[10] = '{16'h0050, 16'h044f, 16'h0a00, 16'h0dff, 16'h00ff,
                            16'h004f, 16'h0450, 16'h09ff, 16'h0e00, 16'hffcb};
    logic [mmv_pkg::NUM_SRC-1:0] int_pend;
    mmv_pkg::mmv_core_req_t core_req;
    mmv_pkg::mmv_core_rsp_t core_rsp;
    mmv_pkg::mmv_stk_req_t stk_req;
    mmv_pkg::mmv_stk_rsp_t stk_rsp;
    int n_fail = 0, cmp_count = 0, lat, k, top;
    ////////////////////////////////////////////////////////////////////////////////
    mmv_memmap_decode #(.WDOG_LIMIT_DEF(16'h0010)) dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_req, .core_ready,
        .core_rsp, .stk_req, .int_pend, .stk_ready, .stk_rsp, .stack_ptr, .wdog_timeout);
    mmv_core_model cpu (.pclk, .core_req, .stk_req, .int_pend, .core_ready, .core_rsp,
        .stk_ready, .stk_rsp);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk("sp pin", 32'h00ff, stack_ptr);
        apb(0, mmv_pkg::OFF_SP, 0);
        chk("sp reg", 32'h00ff, rd);
        apb(0, 12'h0f0, 0);
        chk("unmapped", 1, err);
        $display("reset test done");
        for (k = 0; k < 26; k++) begin
            x = rnd();
            vec[k] = x[15:0];
            apb(1, mmv_pkg::OFF_VEC_BASE + 12'(4 * k), {16'h0, vec[k]});
        end
        for (k = 0; k < 26; k++) begin
            cpu.access(0, 16'hffcc + 16'(2 * k), 8'h00, b, hit);
            chk("vec high", vec[k][15:8], b);
            cpu.access(0, 16'hffcd + 16'(2 * k), 8'h00, b, hit);
            chk("vec low", vec[k][7:0], b);
        end
        for (k = 0; k < 40 && wdog_timeout !== 1'b1; k++) @(posedge pclk);
        chk("wdog pulse", 1, wdog_timeout);
        apb(0, mmv_pkg::OFF_STATUS, 0);
        chk("wdog status", 1, rd[0]);
        apb(1, mmv_pkg::OFF_WDOG_LIMIT, 32'hffff);
        apb(1, mmv_pkg::OFF_STATUS, 32'h3);
        repeat (60) @(posedge pclk);
        apb(0, mmv_pkg::OFF_WDOG_CNT, 0);
        chk("wdog runs", 1, rd > 50);
        x = rnd();
        cpu.access(1, 16'hffff, x[7:0], b, hit);
        apb(0, mmv_pkg::OFF_WDOG_CNT, 0);
        chk("wdog clear", 1, rd < 8);
        cpu.access(0, 16'hffff, 8'h00, b, hit);
        chk("ffff low", vec[25][7:0], b);
        $display("vector test done");
        for (k = 0; k < 10; k++) begin
            x = rnd();
            cpu.access(1, ad[k], x[7:0], b, hit);
            cpu.access(0, ad[k], 8'h00, b, hit);
            chk("ram hit", k < 5, hit);
            chk("ram data", k < 5 ? x[7:0] : 8'h00, b);
        end
        $display("ram test done");
        sp = 16'h0300;
        apb(1, mmv_pkg::OFF_SP, {16'h0, sp});
        for (k = 0; k < 3; k++) begin
            pend = k == 0 ? 32'h0 : rnd();
            x = rnd();
            top = 24;
            for (int i = 0; i < 25; i++) if (pend[i]) top = i;
            cpu.stack(mmv_pkg::STK_INT, x[15:0], {x[31:16], ~x[7:0]}, pend[24:0], lat);
            chk("int lat", 6, lat);
            chk("int vec", vec[top], stk_rsp.vec_addr);
            sp = sp - 16'd5;
            chk("int sp", sp, stack_ptr);
            e = '{x[7:0], x[15:8], x[31:24], x[23:16], ~x[7:0]};
            for (int i = 0; i < 5; i++) begin
                cpu.access(0, sp + 16'd5 - 16'(i), 8'h00, b, hit);
                chk("int frame", e[i], b);
            end
        end
        x = rnd();
        cpu.stack(mmv_pkg::STK_CALL, x[15:0], 24'h0, 25'h0, lat);
        chk("call lat", 3, lat);
        chk("call sp", sp - 16'd2, stack_ptr);
        cpu.access(0, sp, 8'h00, b, hit);
        chk("call low", x[7:0], b);
        cpu.stack(mmv_pkg::STK_PULL, 16'h0, 24'h0, 25'h0, lat);
        chk("pull lat", 2, lat);
        chk("pull sp", sp - 16'd1, stack_ptr);
        chk("pull data", x[15:8], stk_rsp.rdata);
        cpu.stack(mmv_pkg::STK_SP_RELOAD, 16'h0, 24'h0, 25'h0, lat);
        chk("reload lat", 1, lat);
        chk("reload sp", {sp[15:8], 8'hff}, stack_ptr);
        apb(1, mmv_pkg::OFF_SP, 32'h0500);
        cpu.stack(mmv_pkg::STK_CALL, 16'h1234, 24'h0, 25'h0, lat);
        chk("fault sp", 16'h04fe, stack_ptr);
        chk("stk fault", 1, stk_rsp.fault);
        apb(0, mmv_pkg::OFF_STATUS, 0);
        chk("status", 32'h2, rd);
        $display("stack test done");
        print_verdict();
    end
endmodule // test_memory_map_vector_decode
`default_nettype wire
